// *** bench/fib_host_model.sv ***
// host serial master model for register access
`timescale 1ns/1ps
module fib_host_model (
    input  wire logic clk_in,
    input  wire logic miso_in,
    output logic      sck_out,
    output logic      select_n_out,
    output logic      mosi_out
);
    initial begin
        sck_out = 1'b0;
        select_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // one frame: command byte, one data byte; returns the second byte seen
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        @(negedge clk_in) select_n_out = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (5) @(negedge clk_in);
            sck_out = 1'b0;
            mosi_out = tx[i];
            repeat (5) @(negedge clk_in);
            rx = {rx[6:0], miso_in};
            sck_out = 1'b1;
        end
        repeat (5) @(negedge clk_in);
        sck_out = 1'b0;
        repeat (5) @(negedge clk_in);
        select_n_out = 1'b1;
        mosi_out = ~mosi_out;
        repeat (4) @(negedge clk_in);
    endtask
endmodule

// *** bench/fib_top_tb.sv ***
// self-checking testbench for the register bank
`timescale 1ns/1ps
module fib_top_tb;
    logic       clk, rstn, sck, sel_n, mosi, miso, oe, cad, sleep, pv, load;
    logic [7:0] ev, pstart, plen, ptr, txb, rxb, pend, q, d;
    logic [7:0] v [4];
    logic [6:0] rw_a [4] = '{7'h0d, 7'h0e, 7'h0f, 7'h11};
    logic [2:0] cr;
    logic [4:0] st;
    int         mismatches, n_compared, seed, nh, np;

    fib_top fib_top_i (.CLOCK_IN(clk), .RSTN_IN(rstn), .SPI_SCK_IN(sck), .SPI_SELECT_N_IN(sel_n),
        .SPI_MOSI_IN(mosi), .SPI_MISO_OUT(miso), .SPI_MISO_OE_OUT(oe), .EVENT_IN(ev), .CAD_ACTIVE_IN(cad),
        .SLEEP_MODE_IN(sleep), .PACKET_VALID_IN(pv), .PACKET_INFO_LOAD_IN(load), .PACKET_START_IN(pstart),
        .PAYLOAD_LENGTH_IN(plen), .CODE_RATE_IN(cr), .MODEM_STATUS_IN(st), .BUFFER_ACCESS_POINTER_OUT(ptr),
        .TX_BUFFER_BASE_OUT(txb), .RX_BUFFER_BASE_OUT(rxb), .IRQ_PENDING_OUT(pend));
    fib_host_model fib_host_model_i (.clk_in(clk), .miso_in(miso), .sck_out(sck), .select_n_out(sel_n),
        .mosi_out(mosi));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [7:0] rst_val(input int a);
        return (a == 8'h0e) ? 8'h80 : (a == 8'h18) ? 8'h10 : 8'h00;
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
            mismatches++;
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] x);
        fib_host_model_i.xfer({1'b1, a, x}, q);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        fib_host_model_i.xfer({1'b0, a, 8'h00}, q);
        chk(q, e);
    endtask
    task automatic pulse(input logic [7:0] e, input logic c, input logic p);
        @(negedge clk);
        ev = e;
        cad = c;
        pv = p;
        @(negedge clk);
        ev = 8'h00;
        pv = 1'b0;
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end
    initial begin
        rstn = 1'b0;
        seed = 32'h750a;
        {ev, cad, sleep, pv, load, pstart, plen, cr} = '0;
        st = 5'h10;
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        for (int a = 8'h0d; a <= 8'h18; a++) rd(a[6:0], rst_val(a));
        rd(7'h00, 8'h00);
        chk({7'h00, oe}, 8'h00);
        chk(txb, 8'h80);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            v[i] = 8'($random(seed));
            wr(rw_a[i], v[i]);
            rd(rw_a[i], v[i]);
        end
        chk(ptr, v[0]);
        chk(txb, v[1]);
        chk(rxb, v[2]);
        wr(7'h13, 8'hff);
        rd(7'h13, 8'h00);
        $display("test rw done");
        for (int b = 0; b < 8; b++) begin
            pulse(8'h01 << b, 1'b1, 1'b0);
            rd(7'h12, 8'hff >> (7 - b));
        end
        chk(pend, ~v[3]);
        wr(7'h11, 8'hff);
        chk(pend, 8'h00);
        d = 8'($random(seed));
        wr(7'h12, d);
        rd(7'h12, ~d);
        wr(7'h12, 8'hff);
        pulse(8'h01, 1'b0, 1'b0);
        rd(7'h12, 8'h00);
        $display("test flags done");
        cr = 3'($random(seed));
        st = 5'($random(seed));
        nh = 256 + {$random(seed)} % 16;
        np = nh - 3;
        @(negedge clk) sleep = 1'b1;
        @(negedge clk) sleep = 1'b0;
        for (int i = 0; i < nh; i++) pulse(8'h10, 1'b0, 1'(i < np));
        rd(7'h14, nh[15:8]);
        rd(7'h15, nh[7:0]);
        rd(7'h16, np[15:8]);
        rd(7'h17, np[7:0]);
        rd(7'h18, {cr, st});
        @(negedge clk) sleep = 1'b1;
        @(negedge clk) sleep = 1'b0;
        rd(7'h14, 8'h00);
        rd(7'h17, 8'h00);
        $display("test counters done");
        pstart = 8'($random(seed));
        plen = 8'($random(seed));
        @(negedge clk) load = 1'b1;
        @(negedge clk) load = 1'b0;
        rd(7'h10, pstart);
        rd(7'h13, plen);
        $display("test packet info done");
        give_verdict();
    end
endmodule

// *** rtl/fib_event_counter.sv ***
// event counter with synchronous clear
`timescale 1ns/1ps
module fib_event_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic             clear_in,
    input  wire logic             step_in,
    output logic      [WIDTH-1:0] count_out
);

    // ****************************************
    // counter
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_out <= '0;
        // R12 sleep clears count
        end else if (clear_in) begin
            count_out <= '0;
        end else if (step_in) begin
            count_out <= count_out + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

// *** rtl/fib_pkg.sv ***
// constants for the buffer pointer, interrupt flag and packet status register bank
// Operation
// R1 - An 8-bit read/write pointer, reset to zero, selects the buffer location used by host serial data accesses.
// R2 - An 8-bit read/write transmit base address, reset to 0x80, marks where the transmitter takes payload.
// R3 - An 8-bit read/write receive base address, reset to zero, marks where the receiver stores payload.
// R4 - A read-only byte gives the buffer start address of the most recently received packet.
// R5 - Each of eight mask bits, reset to zero, suppresses the interrupt of the flag at the same position when set.
// R6 - Flag bits from 7 down are receive timeout, reception done, payload check error, valid header, transmit done,
//      activity detect done, hop channel change and activity detected.
// R7 - Every flag resets to zero and clears when the host writes a one to its position.
// R8 - The activity-detected flag is set when a valid signal is found during an activity detection operation.
// R9 - A read-only byte reports the payload byte count of the latest received packet.
// R10 - A 16-bit count of valid headers is kept and read as separate high and low bytes.
// R11 - A 16-bit count of valid packets is kept and read as separate high and low bytes.
// R12 - Both counts clear to zero whenever the device is in sleep mode.
// R13 - Modem status bits 7 to 5 show the coding-rate code of the most recent received header.
// R14 - Modem status bits 4 to 0 show modem clear (reset one), header info valid, receiving, synchronized, detected.
package fib_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int ADDR_W  = 7;
    localparam int DATA_W  = 8;
    localparam int COUNT_W = 16;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [6:0] OFS_ACCESS_POINTER = 7'h0d;
    localparam logic [6:0] OFS_TX_BASE        = 7'h0e;
    localparam logic [6:0] OFS_RX_BASE        = 7'h0f;
    localparam logic [6:0] OFS_LAST_START     = 7'h10;
    localparam logic [6:0] OFS_IRQ_MASK       = 7'h11;
    localparam logic [6:0] OFS_IRQ_FLAGS      = 7'h12;
    localparam logic [6:0] OFS_PAYLOAD_LENGTH = 7'h13;
    localparam logic [6:0] OFS_HEADER_HIGH    = 7'h14;
    localparam logic [6:0] OFS_HEADER_LOW     = 7'h15;
    localparam logic [6:0] OFS_PACKET_HIGH    = 7'h16;
    localparam logic [6:0] OFS_PACKET_LOW     = 7'h17;
    localparam logic [6:0] OFS_MODEM_STATE    = 7'h18;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_ACCESS_POINTER = 8'h00;
    localparam logic [7:0] RST_TX_BASE        = 8'h80;
    localparam logic [7:0] RST_RX_BASE        = 8'h00;
    localparam logic [7:0] RST_LAST_START     = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK       = 8'h00;
    localparam logic [7:0] RST_IRQ_FLAGS      = 8'h00;
    localparam logic [7:0] RST_PAYLOAD_LENGTH = 8'h00;
    localparam logic [2:0] RST_CODE_RATE      = 3'h0;
    localparam logic [4:0] RST_STATUS_LOW     = 5'h10;

    // ****************************************
    // field positions
    // ****************************************
    localparam int FLAG_RX_TIMEOUT     = 7;
    localparam int FLAG_RX_DONE        = 6;
    localparam int FLAG_CHECK_ERROR    = 5;
    localparam int FLAG_HEADER_VALID   = 4;
    localparam int FLAG_TX_DONE        = 3;
    localparam int FLAG_DETECT_DONE    = 2;
    localparam int FLAG_HOP_CHANGE     = 1;
    localparam int FLAG_ACTIVITY_FOUND = 0;
    localparam int CODE_RATE_MSB       = 7;
    localparam int CODE_RATE_LSB       = 5;
    localparam int STATUS_LOW_MSB      = 4;

    // ****************************************
    // serial frame
    // ****************************************
    localparam int         SPI_WNR_BIT  = 7;
    localparam logic [2:0] SPI_LAST_BIT = 3'h7;

endpackage

// *** rtl/fib_spi_slave.sv ***
// serial register access slave, mode 0, address byte then auto-incrementing data bytes
`timescale 1ns/1ps
module fib_spi_slave (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       sck_in,
    input  wire logic       select_n_in,
    input  wire logic       mosi_in,
    output logic            miso_out,
    output logic            miso_oe_out,
    output logic      [6:0] rd_addr_out,
    output logic      [6:0] wr_addr_out,
    output logic            wr_out,
    output logic      [7:0] wdata_out,
    input  wire logic [7:0] rdata_in
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic       sck_s1;
    logic       sck_s2;
    logic       sck_s3;
    logic       sel_s1;
    logic       sel_s2;
    logic       mosi_s1;
    logic       mosi_s2;
    logic       rise;
    logic       active;
    logic       last_bit;
    logic [7:0] next_byte;
    logic [2:0] bit_cnt;
    logic       first;
    logic       write_mode;
    logic       load;
    logic [6:0] shift_in;
    logic [7:0] shift_out;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sck_s1  <= 1'b0;
            sck_s2  <= 1'b0;
            sck_s3  <= 1'b0;
            sel_s1  <= 1'b1;
            sel_s2  <= 1'b1;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
        end else begin
            sck_s1  <= sck_in;
            sck_s2  <= sck_s1;
            sck_s3  <= sck_s2;
            sel_s1  <= select_n_in;
            sel_s2  <= sel_s1;
            mosi_s1 <= mosi_in;
            mosi_s2 <= mosi_s1;
        end
    end

    assign rise      = sck_s2 & ~sck_s3;
    assign active    = ~sel_s2;
    assign last_bit  = rise && (bit_cnt == fib_pkg::SPI_LAST_BIT);
    assign next_byte = {shift_in, mosi_s2};

    // ****************************************
    // frame sequencing
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bit_cnt     <= 3'h0;
            first       <= 1'b1;
            write_mode  <= 1'b0;
            load        <= 1'b0;
            shift_in    <= 7'h00;
            rd_addr_out <= 7'h00;
        end else if (!active) begin
            bit_cnt <= 3'h0;
            first   <= 1'b1;
            load    <= 1'b0;
        end else begin
            load <= 1'b0;
            if (rise) begin
                shift_in <= next_byte[6:0];
                bit_cnt  <= bit_cnt + 3'h1;
            end
            if (last_bit) begin
                first <= 1'b0;
                if (first) begin
                    write_mode  <= next_byte[fib_pkg::SPI_WNR_BIT];
                    rd_addr_out <= next_byte[6:0];
                    load        <= ~next_byte[fib_pkg::SPI_WNR_BIT];
                end else begin
                    rd_addr_out <= rd_addr_out + 7'h01;
                    load        <= ~write_mode;
                end
            end
        end
    end

    // ****************************************
    // write strobe
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_out      <= 1'b0;
            wr_addr_out <= 7'h00;
            wdata_out   <= 8'h00;
        end else begin
            wr_out <= 1'b0;
            if (active && last_bit && !first && write_mode) begin
                wr_out      <= 1'b1;
                wr_addr_out <= rd_addr_out;
                wdata_out   <= next_byte;
            end
        end
    end

    // ****************************************
    // read shifter
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shift_out <= 8'h00;
        end else if (!active) begin
            shift_out <= 8'h00;
        end else if (load) begin
            shift_out <= rdata_in;
        end else if (rise) begin
            shift_out <= {shift_out[6:0], 1'b0};
        end
    end

    assign miso_out    = shift_out[7];
    assign miso_oe_out = active;

endmodule

// *** rtl/fib_top.sv ***
// buffer pointer, interrupt flag, packet counter and modem status register bank
`timescale 1ns/1ps
module fib_top (
    input  wire logic       CLOCK_IN,
    input  wire logic       RSTN_IN,
    input  wire logic       SPI_SCK_IN,
    input  wire logic       SPI_SELECT_N_IN,
    input  wire logic       SPI_MOSI_IN,
    output logic            SPI_MISO_OUT,
    output logic            SPI_MISO_OE_OUT,
    input  wire logic [7:0] EVENT_IN,
    input  wire logic       CAD_ACTIVE_IN,
    input  wire logic       SLEEP_MODE_IN,
    input  wire logic       PACKET_VALID_IN,
    input  wire logic       PACKET_INFO_LOAD_IN,
    input  wire logic [7:0] PACKET_START_IN,
    input  wire logic [7:0] PAYLOAD_LENGTH_IN,
    input  wire logic [2:0] CODE_RATE_IN,
    input  wire logic [4:0] MODEM_STATUS_IN,
    output logic      [7:0] BUFFER_ACCESS_POINTER_OUT,
    output logic      [7:0] TX_BUFFER_BASE_OUT,
    output logic      [7:0] RX_BUFFER_BASE_OUT,
    output logic      [7:0] IRQ_PENDING_OUT
);

    // ****************************************
    // declarations
    // ****************************************
    logic [6:0]  rd_addr;
    logic [6:0]  wr_addr;
    logic        reg_wr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  buffer_access_pointer;
    logic [7:0]  tx_buffer_base;
    logic [7:0]  rx_buffer_base;
    logic [7:0]  last_packet_start;
    logic [7:0]  interrupt_mask;
    logic [7:0]  interrupt_flags;
    logic [7:0]  rx_payload_length;
    logic [2:0]  last_header_code_rate;
    logic [4:0]  modem_state_bits;
    logic [7:0]  flag_set;
    logic [7:0]  flag_clear;
    logic [15:0] header_count;
    logic [15:0] packet_count;

    function automatic logic write_hit(input logic [6:0] addr, input logic [6:0] ofs, input logic wr);
        write_hit = wr && (addr == ofs);
    endfunction

    // ****************************************
    // register access
    // ****************************************
    fib_spi_slave u_spi (
        .clk_in      (CLOCK_IN),
        .rstn_in     (RSTN_IN),
        .sck_in      (SPI_SCK_IN),
        .select_n_in (SPI_SELECT_N_IN),
        .mosi_in     (SPI_MOSI_IN),
        .miso_out    (SPI_MISO_OUT),
        .miso_oe_out (SPI_MISO_OE_OUT),
        .rd_addr_out (rd_addr),
        .wr_addr_out (wr_addr),
        .wr_out      (reg_wr),
        .wdata_out   (wdata),
        .rdata_in    (rdata)
    );

    // ****************************************
    // pointer registers
    // ****************************************
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            buffer_access_pointer <= fib_pkg::RST_ACCESS_POINTER;
        // R1 access pointer write
        end else if (write_hit(wr_addr, fib_pkg::OFS_ACCESS_POINTER, reg_wr)) begin
            buffer_access_pointer <= wdata;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            tx_buffer_base <= fib_pkg::RST_TX_BASE;
        // R2 transmit base write
        end else if (write_hit(wr_addr, fib_pkg::OFS_TX_BASE, reg_wr)) begin
            tx_buffer_base <= wdata;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rx_buffer_base <= fib_pkg::RST_RX_BASE;
        // R3 receive base write
        end else if (write_hit(wr_addr, fib_pkg::OFS_RX_BASE, reg_wr)) begin
            rx_buffer_base <= wdata;
        end
    end

    assign BUFFER_ACCESS_POINTER_OUT = buffer_access_pointer;
    assign TX_BUFFER_BASE_OUT        = tx_buffer_base;
    assign RX_BUFFER_BASE_OUT        = rx_buffer_base;

    // ****************************************
    // packet information
    // ****************************************
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            last_packet_start <= fib_pkg::RST_LAST_START;
            rx_payload_length <= fib_pkg::RST_PAYLOAD_LENGTH;
        // R4 R9 latch packet start and length
        end else if (PACKET_INFO_LOAD_IN) begin
            last_packet_start <= PACKET_START_IN;
            rx_payload_length <= PAYLOAD_LENGTH_IN;
        end
    end

    // ****************************************
    // interrupt mask and flags
    // ****************************************
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            interrupt_mask <= fib_pkg::RST_IRQ_MASK;
        end else if (write_hit(wr_addr, fib_pkg::OFS_IRQ_MASK, reg_wr)) begin
            interrupt_mask <= wdata;
        end
    end

    // R8 detection gated by activity scan
    always_comb begin
        flag_set = EVENT_IN;
        flag_set[fib_pkg::FLAG_ACTIVITY_FOUND] = EVENT_IN[fib_pkg::FLAG_ACTIVITY_FOUND] & CAD_ACTIVE_IN;
    end

    assign flag_clear = write_hit(wr_addr, fib_pkg::OFS_IRQ_FLAGS, reg_wr) ? wdata : 8'h00;

    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            interrupt_flags <= fib_pkg::RST_IRQ_FLAGS;
        // R6 R7 sticky flags, set wins
        end else begin
            interrupt_flags <= (interrupt_flags & ~flag_clear) | flag_set;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            IRQ_PENDING_OUT <= 8'h00;
        // R5 mask suppresses flag
        end else begin
            IRQ_PENDING_OUT <= interrupt_flags & ~interrupt_mask;
        end
    end

    // ****************************************
    // valid header and packet counters
    // ****************************************
    // R10 header count
    fib_event_counter #(
        .WIDTH (fib_pkg::COUNT_W)
    ) u_header_count (
        .clk_in    (CLOCK_IN),
        .rstn_in   (RSTN_IN),
        .clear_in  (SLEEP_MODE_IN),
        .step_in   (EVENT_IN[fib_pkg::FLAG_HEADER_VALID]),
        .count_out (header_count)
    );

    // R11 packet count
    fib_event_counter #(
        .WIDTH (fib_pkg::COUNT_W)
    ) u_packet_count (
        .clk_in    (CLOCK_IN),
        .rstn_in   (RSTN_IN),
        .clear_in  (SLEEP_MODE_IN),
        .step_in   (PACKET_VALID_IN),
        .count_out (packet_count)
    );

    // ****************************************
    // modem status
    // ****************************************
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            last_header_code_rate <= fib_pkg::RST_CODE_RATE;
        // R13 code rate on header
        end else if (EVENT_IN[fib_pkg::FLAG_HEADER_VALID]) begin
            last_header_code_rate <= CODE_RATE_IN;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            modem_state_bits <= fib_pkg::RST_STATUS_LOW;
        // R14 live status bits
        end else begin
            modem_state_bits <= MODEM_STATUS_IN;
        end
    end

    // ****************************************
    // read multiplexer
    // ****************************************
    always_comb begin
        unique case (rd_addr)
            fib_pkg::OFS_ACCESS_POINTER: rdata = buffer_access_pointer;
            fib_pkg::OFS_TX_BASE:        rdata = tx_buffer_base;
            fib_pkg::OFS_RX_BASE:        rdata = rx_buffer_base;
            fib_pkg::OFS_LAST_START:     rdata = last_packet_start;
            fib_pkg::OFS_IRQ_MASK:       rdata = interrupt_mask;
            fib_pkg::OFS_IRQ_FLAGS:      rdata = interrupt_flags;
            fib_pkg::OFS_PAYLOAD_LENGTH: rdata = rx_payload_length;
            fib_pkg::OFS_HEADER_HIGH:    rdata = header_count[15:8];
            fib_pkg::OFS_HEADER_LOW:     rdata = header_count[7:0];
            fib_pkg::OFS_PACKET_HIGH:    rdata = packet_count[15:8];
            fib_pkg::OFS_PACKET_LOW:     rdata = packet_count[7:0];
            fib_pkg::OFS_MODEM_STATE:    rdata = {last_header_code_rate, modem_state_bits};
            default:                     rdata = 8'h00;
        endcase
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_pointer_write;
        @(posedge CLOCK_IN) disable iff (!RSTN_IN)
        reg_wr && (wr_addr == fib_pkg::OFS_ACCESS_POINTER) |=> BUFFER_ACCESS_POINTER_OUT == $past(wdata);
    endproperty
    a_pointer_write: assert property (p_pointer_write) // R1
        else $error("access pointer not written");

    property p_tx_base_write;
        @(posedge CLOCK_IN) disable iff (!RSTN_IN)
        reg_wr && (wr_addr == fib_pkg::OFS_TX_BASE) |=> TX_BUFFER_BASE_OUT == $past(wdata);
    endproperty
    a_tx_base_write: assert property (p_tx_base_write) // R2
        else $error("transmit base not written");

    property p_rx_base_hold;
        @(posedge CLOCK_IN) disable iff (!RSTN_IN)
        !(reg_wr && (wr_addr == fib_pkg::OFS_RX_BASE)) |=> $stable(RX_BUFFER_BASE_OUT);
    endproperty
    a_rx_base_hold: assert property (p_rx_base_hold) // R3
        else $error("receive base changed without write");

    property p_packet_info;
        @(posedge CLOCK_IN) disable iff (!RSTN_IN)
        PACKET_INFO_LOAD_IN |=> (last_packet_start == $past(PACKET_START_IN))
                                && (rx_payload_length == $past(PAYLOAD_LENGTH_IN));
    endproperty
    a_packet_info: assert property (p_packet_info) // R4
        else $error("packet start or length not latched");

    property p_mask_all;
        @(posedge CLOCK_IN) disable iff (!RSTN_IN)
        (interrupt_mask == 8'hff) |=> (IRQ_PENDING_OUT == 8'h00);
    endproperty
    a_mask_all: assert property (p_mask_all) // R5
        else $error("masked flag reached pending output");

    property p_done_position;
        @(posedge CLOCK_IN) disable iff (!RSTN_IN)
        EVENT_IN[fib_pkg::FLAG_RX_DONE] && !interrupt_mask[fib_pkg::FLAG_RX_DONE]
        |=> interrupt_flags[fib_pkg::FLAG_RX_DONE] ##1 IRQ_PENDING_OUT[fib_pkg::FLAG_RX_DONE];
    endproperty
    a_done_position: assert property (p_done_position) // R6
        else $error("reception done not at its bit");

    property p_flag_clear;
        @(posedge CLOCK_IN) disable iff (!RSTN_IN)
        reg_wr && (wr_addr == fib_pkg::OFS_IRQ_FLAGS) && wdata[fib_pkg::FLAG_RX_TIMEOUT]
        && !EVENT_IN[fib_pkg::FLAG_RX_TIMEOUT] |=> !interrupt_flags[fib_pkg::FLAG_RX_TIMEOUT];
    endproperty
    a_flag_clear: assert property (p_flag_clear) // R7
        else $error("write one did not clear flag");

    property p_detect_gate;
        @(posedge CLOCK_IN) disable iff (!RSTN_IN)
        !CAD_ACTIVE_IN |=> !$rose(interrupt_flags[fib_pkg::FLAG_ACTIVITY_FOUND]);
    endproperty
    a_detect_gate: assert property (p_detect_gate) // R8
        else $error("activity flag set outside detection");

    property p_header_step;
        @(posedge CLOCK_IN) disable iff (!RSTN_IN)
        EVENT_IN[fib_pkg::FLAG_HEADER_VALID] && !SLEEP_MODE_IN |=> header_count == $past(header_count) + 16'h0001;
    endproperty
    a_header_step: assert property (p_header_step) // R10
        else $error("header count did not step");

    property p_packet_step;
        @(posedge CLOCK_IN) disable iff (!RSTN_IN)
        PACKET_VALID_IN && !SLEEP_MODE_IN |=> packet_count == $past(packet_count) + 16'h0001;
    endproperty
    a_packet_step: assert property (p_packet_step) // R11
        else $error("packet count did not step");

    property p_sleep_clear;
        @(posedge CLOCK_IN) disable iff (!RSTN_IN)
        SLEEP_MODE_IN |=> (header_count == 16'h0000) && (packet_count == 16'h0000);
    endproperty
    a_sleep_clear: assert property (p_sleep_clear) // R12
        else $error("counters not cleared in sleep");

    property p_code_rate;
        @(posedge CLOCK_IN) disable iff (!RSTN_IN)
        EVENT_IN[fib_pkg::FLAG_HEADER_VALID] |=> last_header_code_rate == $past(CODE_RATE_IN);
    endproperty
    a_code_rate: assert property (p_code_rate) // R13
        else $error("code rate not captured");

    property p_status_low;
        @(posedge CLOCK_IN) disable iff (!RSTN_IN)
        1'b1 |=> modem_state_bits == $past(MODEM_STATUS_IN);
    endproperty
    a_status_low: assert property (p_status_low) // R14
        else $error("status bits not following modem");

endmodule
